// ==== core/gpio_port.sv ====
/*
 GPIO enable, direction and level registers of a sensor converter with pad control.
 Assumes a simple register port and synchronous pin inputs on sys_clk.
*/
`timescale 1ns/1ps
`include "gpio_defines.svh"

module gpio_port
   import gpio_pkg::*;
#(
   parameter bit EIGHT_PIN = 1'b1
)(
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rdata,
   input  wire logic       ref0_positive_pin_in,
   output logic            ref0_positive_pin_out,
   output logic            ref0_positive_pin_oe_n,
   input  wire logic       ref0_negative_pin_in,
   output logic            ref0_negative_pin_out,
   output logic            ref0_negative_pin_oe_n,
   input  wire logic [7:2] analog_input_pin_n_in,
   output logic      [7:2] analog_input_pin_n_out,
   output logic      [7:2] analog_input_pin_n_oe_n
);

   // ==========================================
   // Register state
   logic [7:0] pin_enable_bits_q, pin_enable_bits_d;
   logic [7:0] direction_bits_q,  direction_bits_d;
   logic [7:0] level_bits_q,      level_bits_d;
   logic [7:0] rdata_d;
   logic [7:0] impl_mask;
   reg_sel_t   sel;
   logic [7:0] pad_in, pad_out, pad_oe_n, pad_sample;
   logic [7:0] sample_expect;

   // Absent pins of the small variant are masked everywhere
   assign impl_mask = EIGHT_PIN ? 8'hff : 8'h0f;

   // Address decode
   always_comb
   begin
      unique case (addr)
         `GPIO_PIN_ENABLE_OFS: sel = SEL_ENABLE;
         `GPIO_DIRECTION_OFS:  sel = SEL_DIR;
         `GPIO_LEVEL_OFS:      sel = SEL_LEVEL;
         default:              sel = SEL_NONE;
      endcase
   end

   // Next register values; reserved bits are dropped on write
   always_comb
   begin
      pin_enable_bits_d = pin_enable_bits_q;
      direction_bits_d  = direction_bits_q;
      level_bits_d      = level_bits_q;
      if (wr_en)
      begin
         unique case (sel)
            SEL_ENABLE: pin_enable_bits_d = wdata & impl_mask;
            SEL_DIR:    direction_bits_d  = wdata & impl_mask;
            SEL_LEVEL:  level_bits_d      = wdata & impl_mask;
            SEL_NONE:   ;
         endcase
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_d = 8'h00;
      if (rd_en)
      begin
         unique case (sel)
            SEL_ENABLE: rdata_d = pin_enable_bits_q & impl_mask;
            SEL_DIR:    rdata_d = direction_bits_q & impl_mask;
            SEL_LEVEL:  rdata_d = level_bits_q & impl_mask;
            SEL_NONE:   rdata_d = 8'h00;
         endcase
      end
   end

   // Registers; read data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pin_enable_bits_q <= `GPIO_REG_RESET;
         direction_bits_q  <= `GPIO_REG_RESET;
         level_bits_q      <= `GPIO_REG_RESET;
         rdata             <= 8'h00;
      end
      else if (clk_en)
      begin
         pin_enable_bits_q <= pin_enable_bits_d;
         direction_bits_q  <= direction_bits_d;
         level_bits_q      <= level_bits_d;
         rdata             <= rdata_d;
      end
   end

   // ==========================================
   // Pad slices, one per GPIO bit
   assign pad_in = {analog_input_pin_n_in, ref0_negative_pin_in, ref0_positive_pin_in};

   genvar g;
   generate
      for (g = 0; g < `GPIO_MAX_PINS; g++)
      begin : g_pin
         gpio_pin_cell u_cell (
            .sys_clk     (sys_clk),
            .reset       (reset),
            .clk_en      (clk_en),
            .implemented (impl_mask[g]),
            .enable_bit  (pin_enable_bits_q[g]),
            .dir_bit     (direction_bits_q[g]),
            .level_bit   (level_bits_q[g]),
            .pin_in      (pad_in[g]),
            .pin_out     (pad_out[g]),
            .pin_oe_n    (pad_oe_n[g]),
            .pin_sample  (pad_sample[g])
         );
      end
   endgenerate

   // Bit-to-pin mapping of the shared package pins
   assign ref0_positive_pin_out   = pad_out[0];
   assign ref0_positive_pin_oe_n  = pad_oe_n[0];
   assign ref0_negative_pin_out   = pad_out[1];
   assign ref0_negative_pin_oe_n  = pad_oe_n[1];
   assign analog_input_pin_n_out  = pad_out[7:2];
   assign analog_input_pin_n_oe_n = pad_oe_n[7:2];

   // ==========================================
   // Assertions

   // What each pad slice should capture; only routed input pins sample
   assign sample_expect = pad_in & pin_enable_bits_q & direction_bits_q & impl_mask;
   property p_disabled_floats;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && !pin_enable_bits_q[0]) |=> ref0_positive_pin_oe_n;
   endproperty
   a_disabled_floats: assert property (p_disabled_floats)
      else $error("disabled pin driven");

   property p_output_drives;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && pin_enable_bits_q[1] && !direction_bits_q[1])
         |=> (!ref0_negative_pin_oe_n && ref0_negative_pin_out == $past(level_bits_q[1]));
   endproperty
   a_output_drives: assert property (p_output_drives)
      else $error("output pin not driving stored level");

   property p_input_no_drive;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && direction_bits_q[2]) |=> analog_input_pin_n_oe_n[2];
   endproperty
   a_input_no_drive: assert property (p_input_no_drive)
      else $error("input pin driven");

   property p_high_pin_map;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && pin_enable_bits_q[7] && !direction_bits_q[7])
         |=> (analog_input_pin_n_out[7] == $past(level_bits_q[7]));
   endproperty
   a_high_pin_map: assert property (p_high_pin_map)
      else $error("bit 7 not on analog pin 7");

   property p_reserved_zero;
      @(posedge sys_clk) disable iff (reset)
      !EIGHT_PIN |-> (pin_enable_bits_q[7:4] == 4'h0 && direction_bits_q[7:4] == 4'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits nonzero");

   property p_enable_write;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && wr_en && addr == `GPIO_PIN_ENABLE_OFS)
         |=> pin_enable_bits_q == ($past(wdata) & impl_mask);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable write lost");

   property p_dir_read;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && rd_en && addr == `GPIO_DIRECTION_OFS)
         |=> rdata == ($past(direction_bits_q) & impl_mask);
   endproperty
   a_dir_read: assert property (p_dir_read)
      else $error("direction read wrong");

   property p_level_roundtrip;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && wr_en && addr == `GPIO_LEVEL_OFS) ##1 (clk_en && rd_en && addr == `GPIO_LEVEL_OFS)
         |=> rdata == ($past(wdata, 2) & impl_mask);
   endproperty
   a_level_roundtrip: assert property (p_level_roundtrip)
      else $error("level readback wrong");

   property p_reset_clears;
      @(posedge sys_clk) reset |=> (pin_enable_bits_q == 8'h00 && direction_bits_q == 8'h00
                                   && level_bits_q == 8'h00);
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("reset left state");

   property p_input_capture;
      @(posedge sys_clk) disable iff (reset)
      clk_en |=> pad_sample == $past(sample_expect);
   endproperty
   a_input_capture: assert property (p_input_capture)
      else $error("input pin capture wrong");

   property p_read_idle_zero;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && !rd_en) |=> rdata == 8'h00;
   endproperty
   a_read_idle_zero: assert property (p_read_idle_zero)
      else $error("read data outlived its cycle");

   property p_unmapped_read;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && rd_en && sel == SEL_NONE) |=> rdata == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped offset read nonzero");

   property p_unmapped_write;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && wr_en && sel == SEL_NONE)
         |=> ($stable(pin_enable_bits_q) && $stable(direction_bits_q) && $stable(level_bits_q));
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("unmapped offset write changed state");

   property p_freeze;
      @(posedge sys_clk) disable iff (reset)
      !clk_en |=> ($stable(pin_enable_bits_q) && $stable(direction_bits_q)
                   && $stable(level_bits_q) && $stable(rdata) && $stable(pad_oe_n));
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while frozen");

   property p_small_pins_quiet;
      @(posedge sys_clk) disable iff (reset)
      !EIGHT_PIN |-> analog_input_pin_n_oe_n[7:4] == 4'hf;
   endproperty
   a_small_pins_quiet: assert property (p_small_pins_quiet)
      else $error("absent pin driven");

   property p_dir_write;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && wr_en && addr == `GPIO_DIRECTION_OFS)
         |=> direction_bits_q == ($past(wdata) & impl_mask);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write lost");

   property p_level_write;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && wr_en && addr == `GPIO_LEVEL_OFS)
         |=> level_bits_q == ($past(wdata) & impl_mask);
   endproperty
   a_level_write: assert property (p_level_write)
      else $error("level write lost");

   property p_enable_read;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && rd_en && addr == `GPIO_PIN_ENABLE_OFS)
         |=> rdata == ($past(pin_enable_bits_q) & impl_mask);
   endproperty
   a_enable_read: assert property (p_enable_read)
      else $error("enable read wrong");

   property p_drive_low;
      @(posedge sys_clk) disable iff (reset)
      (clk_en && pin_enable_bits_q[4] && !direction_bits_q[4] && !level_bits_q[4])
         |=> (!analog_input_pin_n_oe_n[4] && !analog_input_pin_n_out[4]);
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("output pin not driven low");

   c_drive_high: cover property (@(posedge sys_clk) disable iff (reset)
      !ref0_positive_pin_oe_n && ref0_positive_pin_out);
   c_input_mode: cover property (@(posedge sys_clk) disable iff (reset)
      pin_enable_bits_q[3] && direction_bits_q[3]);
   c_read_level: cover property (@(posedge sys_clk) disable iff (reset)
      rd_en && addr == `GPIO_LEVEL_OFS);
   c_back_to_back: cover property (@(posedge sys_clk) disable iff (reset)
      (wr_en && addr == `GPIO_LEVEL_OFS) ##1 rd_en);

endmodule : gpio_port

// ==== core/gpio_defines.svh ====
/*
 Register offsets, pin counts and reset values of the converter GPIO block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ==========================================
// Register map
`define GPIO_ADDR_W          4
`define GPIO_PIN_ENABLE_OFS  4'hc
`define GPIO_DIRECTION_OFS   4'hd
`define GPIO_LEVEL_OFS       4'he
`define GPIO_REG_RESET       8'h00
`define GPIO_LOW_PINS        4
`define GPIO_MAX_PINS        8

`endif

// ==== core/gpio_pkg.sv ====
/*
 Types shared by the converter GPIO block.
 Assumes the defines header is compiled first.
*/
package gpio_pkg;

   // ==========================================
   // Register selector
   typedef enum logic [3:0] {
      SEL_NONE   = 4'h1,
      SEL_ENABLE = 4'h2,
      SEL_DIR    = 4'h4,
      SEL_LEVEL  = 4'h8
   } reg_sel_t;

endpackage : gpio_pkg

// ==== core/gpio_pin_cell.sv ====
/*
 One GPIO pad slice: output drive, enable and input capture for one pin.
 Assumes synchronous pin inputs and an active high synchronous reset.
*/
`timescale 1ns/1ps
`include "gpio_defines.svh"

module gpio_pin_cell (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   input  wire logic implemented,
   input  wire logic enable_bit,
   input  wire logic dir_bit,
   input  wire logic level_bit,
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe_n,
   output logic      pin_sample
);

   logic out_d, oe_n_d, smp_d;

   // Drive only when routed and output; an absent pin never drives
   always_comb
   begin
      out_d  = 1'b0;
      oe_n_d = 1'b1;
      smp_d  = 1'b0;
      if (implemented && enable_bit)
      begin
         if (!dir_bit)
         begin
            out_d  = level_bit;
            oe_n_d = 1'b0;
         end
         else
         begin
            smp_d = pin_in;
         end
      end
   end

   // Pad register
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pin_out    <= 1'b0;
         pin_oe_n   <= 1'b1;
         pin_sample <= 1'b0;
      end
      else if (clk_en)
      begin
         pin_out    <= out_d;
         pin_oe_n   <= oe_n_d;
         pin_sample <= smp_d;
      end
   end

endmodule : gpio_pin_cell

// ==== test/pin_partner.sv ====
/*
 Far-side model: outside signals on the shared analog/GPIO pins.
 Assumes active-low pad enables and no pull on the lines.
*/
`timescale 1ns/1ps

module pin_partner (
   input  wire logic       sys_clk,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe_n,
   output logic      [7:0] pin_level
);
   logic [7:0] ext_q = 8'h5a;

   // ==========================================
   // Undriven lines toggle each cycle, so no stale value can pass
   always @(posedge sys_clk)
      ext_q <= ~ext_q;

   // Device pad wins wherever its enable is low
   assign pin_level = (pad_out & ~pad_oe_n) | (ext_q & pad_oe_n);
endmodule : pin_partner

// ==== test/tb.sv ====
/*
 Self-checking bench: eight-pin and four-pin ports on one register bus.
 Assumes the design, package and pin_partner are compiled first.
*/
`timescale 1ns/1ps

module tb;
   logic       sys_clk = 1'b0;
   logic       reset   = 1'b1;
   logic       clk_en  = 1'b1;
   logic [3:0] addr    = 4'h0;
   logic [7:0] wdata   = 8'h00;
   logic       wr_en   = 1'b0;
   logic       rd_en   = 1'b0;
   wire  [7:0] rdv [2];
   wire  [7:0] outv[2];
   wire  [7:0] oev [2];
   wire  [7:0] lvv [2];
   int         bad_count = 0;
   int         checks    = 0;

   always #10 sys_clk = ~sys_clk;

   // ==========================================
   // Index 0 is the four-pin variant, index 1 the eight-pin one
   for (genvar g = 0; g < 2; g++)
   begin : g_var
      gpio_port #(.EIGHT_PIN(g == 1)) gpio_port_i (
         .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .addr(addr),
         .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdv[g]),
         .ref0_positive_pin_in(lvv[g][0]), .ref0_positive_pin_out(outv[g][0]),
         .ref0_positive_pin_oe_n(oev[g][0]), .ref0_negative_pin_in(lvv[g][1]),
         .ref0_negative_pin_out(outv[g][1]), .ref0_negative_pin_oe_n(oev[g][1]),
         .analog_input_pin_n_in(lvv[g][7:2]), .analog_input_pin_n_out(outv[g][7:2]),
         .analog_input_pin_n_oe_n(oev[g][7:2]));
      pin_partner pin_partner_i (.sys_clk(sys_clk), .pad_out(outv[g]),
         .pad_oe_n(oev[g]), .pin_level(lvv[g]));
   end

   // ==========================================
   // Bus tasks and compares
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask : wr

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] e8, input logic [7:0] e4);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(negedge sys_clk);
      chk(rdv[1], e8);
      chk(rdv[0], e4);
   endtask : rd

   // Pads lag the write strobe by two edges
   task automatic pads(input logic [7:0] oe8, o8, oe4, o4);
      repeat (2) @(negedge sys_clk);
      chk(oev[1], oe8);
      chk(outv[1] & ~oev[1], o8);
      chk(oev[0], oe4);
      chk(outv[0] & ~oev[0], o4);
   endtask : pads

   // ==========================================
   // Scenarios
   task automatic t_reset;
      rd(4'hc, 8'h00, 8'h00);
      rd(4'hd, 8'h00, 8'h00);
      rd(4'he, 8'h00, 8'h00);
      pads(8'hff, 8'h00, 8'hff, 8'h00);
   endtask : t_reset

   task automatic t_regs;
      for (int i = 12; i < 15; i++)
      begin
         wr(4'(i), 8'ha5);
         rd(4'(i), 8'ha5, 8'h05);
      end
      wr(4'h3, 8'hff);
      rd(4'h3, 8'h00, 8'h00);
      // A frozen block must ignore the write
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(4'hc, 8'h00);
      clk_en <= 1'b1;
      rd(4'hc, 8'ha5, 8'h05);
   endtask : t_regs

   task automatic t_pads;
      wr(4'hc, 8'hff);
      wr(4'hd, 8'h05);
      wr(4'he, 8'ha6);
      pads(8'h05, 8'ha2, 8'hf5, 8'h02);
      rd(4'he, 8'ha6, 8'h06);
      wr(4'hc, 8'h00);
      pads(8'hff, 8'h00, 8'hff, 8'h00);
   endtask : t_pads

   // Write then read with no gap; read data stand one cycle only
   task automatic t_back2back;
      @(posedge sys_clk);
      addr  <= 4'he;
      wdata <= 8'h3c;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(negedge sys_clk);
      chk(rdv[1], 8'h3c);
      chk(rdv[0], 8'h0c);
      @(negedge sys_clk);
      chk(rdv[1], 8'h00);
      chk(rdv[0], 8'h00);
   endtask : t_back2back

   // Reset in mid-run while pads drive must clear enable and level registers and pads
   task automatic t_midreset;
      wr(4'hc, 8'hff);
      pads(8'h05, 8'h38, 8'hf5, 8'h08);
      @(posedge sys_clk);
      reset <= 1'b1;
      @(posedge sys_clk);
      reset <= 1'b0;
      pads(8'hff, 8'h00, 8'hff, 8'h00);
      rd(4'hc, 8'h00, 8'h00);
      rd(4'he, 8'h00, 8'h00);
   endtask : t_midreset

   task automatic report_and_stop;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // Guard against a hang
   initial
   begin
      #200us;
      bad_count++;
      report_and_stop();
   end

   initial
   begin
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_regs();
      t_pads();
      t_back2back();
      t_midreset();
      report_and_stop();
   end
endmodule : tb
